// *** wnc_pkg.sv ***
// Purpose: Shared constants and types for the wiper/NV control block.
// Assumes: 250 MHz system clock; SPI pins are asynchronous to it.
// Notes: NV access time is a modelled figure, not a cell property.
package wnc_pkg;
    localparam int NUM_CHAN = 4;
    localparam int NUM_SLOT = 4;
    localparam int TAP_W = 8;
    localparam int WORD_W = 9;
    localparam int FRAME_BITS = 24;

    // Field positions in the 24-bit command word
    localparam int OPC_HI = 23;
    localparam int OPC_LO = 20;
    localparam int SLOT_HI = 19;
    localparam int SLOT_LO = 18;
    localparam int CHAN_HI = 17;
    localparam int CHAN_LO = 16;
    localparam int BUFSEL_POS = 8;

    // Timing
    localparam int CLK_PERIOD_NS = 4;
    localparam int NV_ACCESS_NS = 1000;
    // Least time, rounded up to whole cycles
    localparam int NV_ACCESS_CYC = (NV_ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int BUSY_W = 9;
    localparam int BITCNT_W = 5;

    // Reset values and tap limits
    localparam logic [8:0] NV_RESET_WORD = 9'h080;
    localparam logic [7:0] TAP_RESET = 8'h00;
    localparam logic [7:0] TAP_MAX = 8'hFF;

    typedef enum logic [3:0] {
        OP_NOP = 4'h0,
        OP_WAKE = 4'h1,
        OP_PROG_NV = 4'h2,
        OP_SAVE_NV = 4'h3,
        OP_WRITE_TAP = 4'h4,
        OP_STEP_UP = 4'h7,
        OP_SLEEP = 4'h8,
        OP_SOFT_RESET = 4'h9,
        OP_READ_NV = 4'hA,
        OP_RESTORE_NV = 4'hB,
        OP_READ_TAP = 4'hC,
        OP_STEP_DOWN = 4'hF
    } wnc_opcode_t;

    typedef enum logic [2:0] {
        ST_INIT = 3'b001,
        ST_IDLE = 3'b010,
        ST_BUSY = 3'b100
    } wnc_state_t;

    // Per-channel outputs toward the resistor network
    typedef struct packed {
        logic [NUM_CHAN-1:0][TAP_W-1:0] wiperPosition;
        logic [NUM_CHAN-1:0] bufferSelect;
    } wnc_wiper_t;

    typedef struct packed {
        wnc_state_t st;
        logic [BUSY_W-1:0] busyCnt;
        logic [BITCNT_W-1:0] bitCnt;
        logic [FRAME_BITS-1:0] rxShift;
        logic [FRAME_BITS-1:0] txShift;
        logic [FRAME_BITS-1:0] txPend;
        logic txActive;
        logic [2:0] sclkSync;
        logic [2:0] csSync;
        logic [1:0] sdiSync;
        logic [1:0] wpSync;
        wnc_wiper_t wiper;
        logic [NUM_CHAN-1:0][NUM_SLOT-1:0][WORD_W-1:0] nvSlot;
    } wnc_regs_t;
endpackage

// *** wnc_wiper_nvm_control.sv ***
// Purpose: SPI command decoder, tap registers and NV slots of a
//          four-channel 256-tap potentiometer.
// Assumes: SPI pins asynchronous; open-drain pins resolved outside.
// Notes: NV slots are flops modelling nonvolatile cells.
module wnc_wiper_nvm_control #(
    parameter logic [8:0] NV_INIT_WORD = wnc_pkg::NV_RESET_WORD,
    parameter int ACCESS_CYC = wnc_pkg::NV_ACCESS_CYC
) (
    input wire logic clk,
    input wire logic srst,
    input wire logic sclk,
    input wire logic csN,
    input wire logic sdi,
    input wire logic wpN,
    output logic sdoOut,
    output logic sdoOe,
    output logic rdyBusyNOut,
    output logic rdyBusyNOe,
    output wnc_pkg::wnc_wiper_t wiperOut
);
    wnc_pkg::wnc_regs_t state_reg;
    wnc_pkg::wnc_regs_t state_next;

    logic sclkRise;
    logic sclkFall;
    logic csFall;
    logic csRise;
    logic wpActive;
    logic [wnc_pkg::FRAME_BITS-1:0] cmdWord;
    wnc_pkg::wnc_opcode_t opcode;
    logic [1:0] chanSel;
    logic [1:0] slotSel;
    logic [8:0] dataBits;
    logic [wnc_pkg::BUSY_W-1:0] accessLoad;
    logic respPending;

    assign sclkRise = state_reg.sclkSync[1] & ~state_reg.sclkSync[2];
    assign sclkFall = ~state_reg.sclkSync[1] & state_reg.sclkSync[2];
    assign csFall = ~state_reg.csSync[1] & state_reg.csSync[2];
    assign csRise = state_reg.csSync[1] & ~state_reg.csSync[2];
    assign wpActive = ~state_reg.wpSync[1];
    assign accessLoad = wnc_pkg::BUSY_W'(ACCESS_CYC);
    // Read answers always carry a nonzero opcode, so zero means none
    assign respPending = (state_reg.txPend != '0);

    assign cmdWord = state_reg.rxShift;
    assign opcode = wnc_pkg::wnc_opcode_t'(cmdWord[wnc_pkg::OPC_HI:wnc_pkg::OPC_LO]);
    assign chanSel = cmdWord[wnc_pkg::CHAN_HI:wnc_pkg::CHAN_LO];
    assign slotSel = cmdWord[wnc_pkg::SLOT_HI:wnc_pkg::SLOT_LO];
    assign dataBits = cmdWord[wnc_pkg::BUFSEL_POS:0];

    always_comb
    begin
        state_next = state_reg;
        // Pin synchronisers; only stage 1 and 2 feed logic
        state_next.sclkSync = {state_reg.sclkSync[1:0], sclk};
        state_next.csSync = {state_reg.csSync[1:0], csN};
        state_next.sdiSync = {state_reg.sdiSync[0], sdi};
        state_next.wpSync = {state_reg.wpSync[0], wpN};

        // frame opens on chip select low
        if (csFall)
        begin
            state_next.bitCnt = '0;
            state_next.txShift = state_reg.txPend;
            // Sdo stays released unless a read left an answer behind
            state_next.txActive = respPending;
            state_next.txPend = '0;
        end
        else if (!state_reg.csSync[1] && sclkRise)
        begin
            // shift MSB first on rising clock
            state_next.rxShift = {state_reg.rxShift[wnc_pkg::FRAME_BITS-2:0],
                                  state_reg.sdiSync[1]};
            // Count sticks past 24 so long frames cannot wrap back to 24
            if (state_reg.bitCnt != wnc_pkg::BITCNT_W'(wnc_pkg::FRAME_BITS + 1))
            begin
                state_next.bitCnt = state_reg.bitCnt + 1'b1;
            end
        end
        else if (!state_reg.csSync[1] && sclkFall)
        begin
            state_next.txShift = {state_reg.txShift[wnc_pkg::FRAME_BITS-2:0], 1'b0};
        end

        // Let go of sdo as soon as the frame closes
        if (csRise)
        begin
            state_next.txActive = 1'b0;
        end

        case (state_reg.st)
            wnc_pkg::ST_INIT:
            begin
                // One cycle here; ready/busy shows busy meanwhile
                // power-up recall from slot 0
                for (int c = 0; c < wnc_pkg::NUM_CHAN; c++)
                begin
                    state_next.wiper.wiperPosition[c] = state_reg.nvSlot[c][0][7:0];
                    state_next.wiper.bufferSelect[c] =
                        state_reg.nvSlot[c][0][wnc_pkg::BUFSEL_POS];
                end
                state_next.st = wnc_pkg::ST_IDLE;
            end
            wnc_pkg::ST_IDLE:
            begin
                // Only whole 24-bit frames execute; short or long ones drop
                if (csRise && state_reg.bitCnt == wnc_pkg::BITCNT_W'(wnc_pkg::FRAME_BITS))
                begin
                    case (opcode)
                        wnc_pkg::OP_READ_TAP:
                        begin
                            // Answer goes out in the next frame
                            // flow-controlled read of tap
                            state_next.txPend = {cmdWord[23:16], 7'h00,
                                state_reg.wiper.bufferSelect[chanSel],
                                state_reg.wiper.wiperPosition[chanSel]};
                            state_next.busyCnt = accessLoad;
                            state_next.st = wnc_pkg::ST_BUSY;
                        end
                        wnc_pkg::OP_WRITE_TAP:
                        begin
                            state_next.wiper.wiperPosition[chanSel] = dataBits[7:0];
                        end
                        wnc_pkg::OP_READ_NV:
                        begin
                            state_next.txPend = {cmdWord[23:16], 7'h00,
                                state_reg.nvSlot[chanSel][slotSel]};
                            state_next.busyCnt = accessLoad;
                            state_next.st = wnc_pkg::ST_BUSY;
                        end
                        wnc_pkg::OP_PROG_NV:
                        begin
                            if (!wpActive)
                            begin
                                state_next.nvSlot[chanSel][slotSel] = dataBits;
                            end
                            state_next.busyCnt = accessLoad;
                            state_next.st = wnc_pkg::ST_BUSY;
                        end
                        wnc_pkg::OP_RESTORE_NV:
                        begin
                            state_next.wiper.wiperPosition[chanSel] =
                                state_reg.nvSlot[chanSel][slotSel][7:0];
                            state_next.wiper.bufferSelect[chanSel] =
                                state_reg.nvSlot[chanSel][slotSel][wnc_pkg::BUFSEL_POS];
                            state_next.busyCnt = accessLoad;
                            state_next.st = wnc_pkg::ST_BUSY;
                        end
                        wnc_pkg::OP_SAVE_NV:
                        begin
                            if (!wpActive)
                            begin
                                state_next.nvSlot[chanSel][slotSel] = {
                                    state_reg.wiper.bufferSelect[chanSel],
                                    state_reg.wiper.wiperPosition[chanSel]};
                            end
                            state_next.busyCnt = accessLoad;
                            state_next.st = wnc_pkg::ST_BUSY;
                        end
                        wnc_pkg::OP_STEP_UP:
                        begin
                            if (state_reg.wiper.wiperPosition[chanSel] != wnc_pkg::TAP_MAX)
                            begin
                                state_next.wiper.wiperPosition[chanSel] =
                                    state_reg.wiper.wiperPosition[chanSel] + 8'h01;
                            end
                        end
                        wnc_pkg::OP_STEP_DOWN:
                        begin
                            if (state_reg.wiper.wiperPosition[chanSel] != wnc_pkg::TAP_RESET)
                            begin
                                state_next.wiper.wiperPosition[chanSel] =
                                    state_reg.wiper.wiperPosition[chanSel] - 8'h01;
                            end
                        end
                        wnc_pkg::OP_SOFT_RESET:
                        begin
                            // Slot contents survive this reset
                            // same recall as power-up
                            state_next.st = wnc_pkg::ST_INIT;
                        end
                        default:
                        begin
                            // NOP, sleep, wake and unknown codes do nothing here
                            state_next.st = wnc_pkg::ST_IDLE;
                        end
                    endcase
                end
            end
            wnc_pkg::ST_BUSY:
            begin
                // Frames closing in here are dropped; host must poll
                // busy for the whole access cycle
                if (state_reg.busyCnt <= wnc_pkg::BUSY_W'(1))
                begin
                    state_next.busyCnt = '0;
                    state_next.st = wnc_pkg::ST_IDLE;
                end
                else
                begin
                    state_next.busyCnt = state_reg.busyCnt - 1'b1;
                end
            end
            default:
            begin
                // Illegal state code: rerun the slot 0 recall
                state_next.st = wnc_pkg::ST_INIT;
            end
        endcase
    end

    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            state_reg.st <= wnc_pkg::ST_INIT;
            state_reg.busyCnt <= '0;
            state_reg.bitCnt <= '0;
            state_reg.rxShift <= '0;
            state_reg.txShift <= '0;
            state_reg.txPend <= '0;
            state_reg.txActive <= 1'b0;
            state_reg.sclkSync <= 3'h0;
            state_reg.csSync <= 3'h7;
            state_reg.sdiSync <= 2'h0;
            state_reg.wpSync <= 2'h3;
            state_reg.wiper.wiperPosition <= '0;
            state_reg.wiper.bufferSelect <= '0;
            // NV cells would survive power loss; reset seeds them here
            // four 9-bit slots per channel
            for (int c = 0; c < wnc_pkg::NUM_CHAN; c++)
            begin
                for (int s = 0; s < wnc_pkg::NUM_SLOT; s++)
                begin
                    state_reg.nvSlot[c][s] <= NV_INIT_WORD;
                end
            end
        end
        else
        begin
            state_reg <= state_next;
        end
    end

    // Open drain: enable only to pull low
    // Each answer bit stands from one sclk fall to the next
    assign sdoOut = 1'b0;
    assign sdoOe = state_reg.txActive & ~state_reg.txShift[wnc_pkg::FRAME_BITS-1];
    // released high while ready after select
    assign rdyBusyNOut = 1'b0;
    assign rdyBusyNOe = (state_reg.st != wnc_pkg::ST_IDLE);
    // four tap registers to the network
    assign wiperOut = state_reg.wiper;
endmodule // wnc_wiper_nvm_control

// *** wnc_wiper_nvm_control_props.sv ***
// Purpose: Port-level checker for the wiper/NV control block.
// Assumes: Single clock domain, synchronous active-high reset.
// Notes: Windows sized for the host pacing of eight or more clocks.
module wnc_wiper_nvm_control_props #(
    parameter logic [8:0] NV_INIT_WORD = wnc_pkg::NV_RESET_WORD,
    parameter int ACCESS_CYC = wnc_pkg::NV_ACCESS_CYC
) (
    input wire logic clk,
    input wire logic srst,
    input wire logic sclk,
    input wire logic csN,
    input wire logic sdi,
    input wire logic wpN,
    input wire logic sdoOut,
    input wire logic sdoOe,
    input wire logic rdyBusyNOut,
    input wire logic rdyBusyNOe,
    input wire wnc_pkg::wnc_wiper_t wiperOut
);
    localparam int BUSY_MAX = ACCESS_CYC + 2;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (srst);

    AST_OPEN_DRAIN: assert property (!rdyBusyNOut && !sdoOut)
        else $error("open-drain data value not low");
    AST_SDO_IDLE: assert property (csN [*4] |-> !sdoOe)
        else $error("sdo pulled while deselected");
    AST_BUSY_BOUND: assert property ($rose(rdyBusyNOe) |-> ##[1:BUSY_MAX] !rdyBusyNOe)
        else $error("busy held past access cycle");
    AST_BUSY_AFTER_FRAME: assert property ($rose(rdyBusyNOe) |-> csN)
        else $error("busy raised inside a frame");
    AST_CS_FALL_READY: assert property ($fell(csN) && !rdyBusyNOe |=> !rdyBusyNOe [*4])
        else $error("ready not held after select");
    AST_FRAME_STABLE: assert property ((!csN) [*8] |=> $stable(wiperOut))
        else $error("wiper moved mid-frame");
    AST_IDLE_STABLE: assert property ((csN && !rdyBusyNOe) [*8] |=> $stable(wiperOut))
        else $error("wiper moved with no command");
    AST_PWRUP_LOAD: assert property ($fell(srst) |-> ##[1:3]
        (wiperOut.wiperPosition == {4{NV_INIT_WORD[7:0]}} &&
        wiperOut.bufferSelect == {4{NV_INIT_WORD[8]}}))
        else $error("power-up load from slot 0 missing");
endmodule // wnc_wiper_nvm_control_props

bind wnc_wiper_nvm_control wnc_wiper_nvm_control_props #(
    .NV_INIT_WORD(NV_INIT_WORD),
    .ACCESS_CYC(ACCESS_CYC)
) u_wnc_wiper_nvm_control_props (.clk(clk), .srst(srst), .sclk(sclk), .csN(csN), .sdi(sdi),
    .wpN(wpN), .sdoOut(sdoOut), .sdoOe(sdoOe), .rdyBusyNOut(rdyBusyNOut),
    .rdyBusyNOe(rdyBusyNOe), .wiperOut(wiperOut));

// *** wnc_spi_host.sv ***
// Purpose: Behavioural SPI master standing in for the host controller.
// Assumes: sclk phases of four system clocks, above the synchroniser need.
// Notes: sclk idles low and stands still between frames.
module wnc_spi_host (
    input wire logic clk,
    input wire logic rdyBusyN,
    input wire logic sdo,
    output logic sclk,
    output logic csN,
    output logic sdi
);
    timeunit 1ns;
    timeprecision 1ps;
    initial
    begin
        sclk = 1'b0;
        csN = 1'b1;
        sdi = 1'b0;
    end

    task automatic send_cmd(input logic [23:0] cmd, output logic sawBusy,
        output logic [23:0] rx);
        int i;
        int k;
        sawBusy = 1'b0;
        rx = '0;
        @(posedge clk);
        csN <= 1'b0;
        repeat (4) @(posedge clk);
        for (i = 23; i >= 0; i--)
        begin
            sdi <= cmd[i];
            repeat (4) @(posedge clk);
            // Answer bit has stood since the last falling sclk
            rx[i] = sdo;
            sclk <= 1'b1;
            repeat (4) @(posedge clk);
            sclk <= 1'b0;
        end
        repeat (4) @(posedge clk);
        csN <= 1'b1;
        // Released line must not keep the last bit
        sdi <= ~cmd[0];
        for (k = 0; k < 40; k++)
        begin
            @(posedge clk);
            #1;
            if (!rdyBusyN)
                sawBusy = 1'b1;
        end
    endtask
endmodule // wnc_spi_host

// *** wnc_wiper_nvm_control_tb_top.sv ***
// Purpose: Self-checking bench for the wiper/NV control block.
// Assumes: Access cycle shortened to four clocks.
// Notes: Read answers are checked in the frame after the read.
module wnc_wiper_nvm_control_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0;
    logic srst = 1'b1;
    logic wpN = 1'b1;
    logic sclk, csN, sdi, sdoOut, sdoOe, rdyBusyNOut, rdyBusyNOe, sawBusy;
    wire rdyBusyN = ~rdyBusyNOe;
    // Pull-up on the open-drain data line
    wire sdoPin = sdoOe ? sdoOut : 1'b1;
    logic [23:0] rxWord;
    wnc_pkg::wnc_wiper_t wiper, expW;
    int errCount = 0;
    int totalChecks = 0;

    always #2 clk = ~clk;

    wnc_spi_host u_wnc_spi_host (.clk(clk), .rdyBusyN(rdyBusyN), .sclk(sclk), .csN(csN),
        .sdi(sdi), .sdo(sdoPin));
    wnc_wiper_nvm_control #(.ACCESS_CYC(4)) u_wnc_wiper_nvm_control (.clk(clk), .srst(srst),
        .sclk(sclk), .csN(csN), .sdi(sdi), .wpN(wpN), .sdoOut(sdoOut), .sdoOe(sdoOe),
        .rdyBusyNOut(rdyBusyNOut), .rdyBusyNOe(rdyBusyNOe), .wiperOut(wiper));

    task automatic check(input string what, input logic [35:0] seen, input logic [35:0] exp);
        totalChecks++;
        if (seen !== exp)
        begin
            errCount++;
            $display("CHECK FAILED %s expected %0h seen %0h", what, exp, seen);
        end
    endtask

    task automatic cmd(input wnc_pkg::wnc_opcode_t op, input logic [1:0] slot,
        input logic [1:0] ch, input logic [8:0] d);
        logic busyOp;
        // Soft reset shows its reload cycle as busy
        busyOp = op inside {wnc_pkg::OP_PROG_NV, wnc_pkg::OP_SAVE_NV, wnc_pkg::OP_READ_NV,
            wnc_pkg::OP_RESTORE_NV, wnc_pkg::OP_READ_TAP, wnc_pkg::OP_SOFT_RESET};
        u_wnc_spi_host.send_cmd({op, slot, ch, 7'h00, d}, sawBusy, rxWord);
        check("busy seen", 36'(sawBusy), 36'(busyOp));
    endtask

    task automatic t_powerup;
        expW.wiperPosition = {4{8'h80}};
        expW.bufferSelect = 4'h0;
        check("power-up", wiper, expW);
    endtask

    task automatic t_write;
        for (int ch = 0; ch < 4; ch++)
        begin
            cmd(wnc_pkg::OP_WRITE_TAP, 2'h0, 2'(ch), {1'b1, 8'(8'h11 * (ch + 1))});
            expW.wiperPosition[ch] = 8'(8'h11 * (ch + 1));
            check("write tap", wiper, expW);
        end
    endtask

    task automatic t_step;
        cmd(wnc_pkg::OP_WRITE_TAP, 2'h0, 2'h2, 9'h0FE);
        cmd(wnc_pkg::OP_STEP_UP, 2'h0, 2'h2, 9'h000);
        check("step up", 36'(wiper.wiperPosition[2]), 36'h0FF);
        cmd(wnc_pkg::OP_STEP_UP, 2'h0, 2'h2, 9'h000);
        check("up at top", 36'(wiper.wiperPosition[2]), 36'h0FF);
        cmd(wnc_pkg::OP_WRITE_TAP, 2'h0, 2'h2, 9'h001);
        cmd(wnc_pkg::OP_STEP_DOWN, 2'h0, 2'h2, 9'h000);
        check("step down", 36'(wiper.wiperPosition[2]), 36'h000);
        cmd(wnc_pkg::OP_STEP_DOWN, 2'h0, 2'h2, 9'h000);
        check("down at zero", 36'(wiper.wiperPosition[2]), 36'h000);
        expW.wiperPosition[2] = 8'h00;
    endtask

    task automatic t_prog_restore;
        cmd(wnc_pkg::OP_PROG_NV, 2'h2, 2'h1, 9'h1A5);
        cmd(wnc_pkg::OP_RESTORE_NV, 2'h2, 2'h1, 9'h000);
        expW.wiperPosition[1] = 8'hA5;
        expW.bufferSelect[1] = 1'b1;
        check("restore slot 2", wiper, expW);
        cmd(wnc_pkg::OP_RESTORE_NV, 2'h1, 2'h1, 9'h000);
        expW.wiperPosition[1] = 8'h80;
        expW.bufferSelect[1] = 1'b0;
        check("restore slot 1", wiper, expW);
    endtask

    task automatic t_save;
        cmd(wnc_pkg::OP_RESTORE_NV, 2'h2, 2'h1, 9'h000);
        cmd(wnc_pkg::OP_WRITE_TAP, 2'h0, 2'h1, 9'h03C);
        cmd(wnc_pkg::OP_SAVE_NV, 2'h3, 2'h1, 9'h000);
        cmd(wnc_pkg::OP_WRITE_TAP, 2'h0, 2'h1, 9'h000);
        cmd(wnc_pkg::OP_RESTORE_NV, 2'h3, 2'h1, 9'h000);
        expW.wiperPosition[1] = 8'h3C;
        expW.bufferSelect[1] = 1'b1;
        check("save slot 3", wiper, expW);
    endtask

    task automatic t_protect;
        @(posedge clk);
        wpN <= 1'b0;
        cmd(wnc_pkg::OP_PROG_NV, 2'h0, 2'h2, 9'h1FF);
        cmd(wnc_pkg::OP_WRITE_TAP, 2'h0, 2'h2, 9'h044);
        cmd(wnc_pkg::OP_SAVE_NV, 2'h0, 2'h2, 9'h000);
        cmd(wnc_pkg::OP_RESTORE_NV, 2'h0, 2'h2, 9'h000);
        expW.wiperPosition[2] = 8'h80;
        check("protected slot", wiper, expW);
        @(posedge clk);
        wpN <= 1'b1;
    endtask

    task automatic t_soft_reset;
        cmd(wnc_pkg::OP_PROG_NV, 2'h0, 2'h3, 9'h111);
        cmd(wnc_pkg::OP_WRITE_TAP, 2'h0, 2'h3, 9'h022);
        cmd(wnc_pkg::OP_SOFT_RESET, 2'h0, 2'h0, 9'h000);
        expW.wiperPosition = {8'h11, 8'h80, 8'h80, 8'h80};
        expW.bufferSelect = 4'h8;
        check("soft reset", wiper, expW);
    endtask

    task automatic t_read;
        logic [23:0] expRx;
        cmd(wnc_pkg::OP_READ_TAP, 2'h0, 2'h3, 9'h000);
        cmd(wnc_pkg::OP_READ_NV, 2'h2, 2'h1, 9'h000);
        expRx = {wnc_pkg::OP_READ_TAP, 2'h0, 2'h3, 7'h00, 9'h111};
        check("read tap answer", 36'(rxWord), 36'(expRx));
        cmd(wnc_pkg::OP_NOP, 2'h0, 2'h0, 9'h000);
        expRx = {wnc_pkg::OP_READ_NV, 2'h2, 2'h1, 7'h00, 9'h1A5};
        check("read slot answer", 36'(rxWord), 36'(expRx));
        // Nothing pending: sdo must stay released high
        cmd(wnc_pkg::OP_NOP, 2'h0, 2'h0, 9'h000);
        check("sdo released", 36'(rxWord), 36'hFFFFFF);
    endtask

    task automatic closeOut;
        if (errCount == 0 && totalChecks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    initial
    begin
        repeat (12) @(posedge clk);
        srst <= 1'b0;
        repeat (4) @(posedge clk);
        t_powerup();
        t_write();
        t_step();
        t_prog_restore();
        t_save();
        t_protect();
        t_soft_reset();
        t_read();
        closeOut();
    end

    // Whole run is near 7k clocks; allow ample margin
    initial
    begin
        #200000;
        errCount++;
        closeOut();
    end
endmodule // wnc_wiper_nvm_control_tb_top
